// ### bridge_reset_pkg.sv
// constants shared by the bridge reset and hot-plug control block
package bridge_reset_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int MCLK_NS       = 50;     // 20 MHz core clock period
  localparam int AUX_POR_NS    = 1000;   // aux power-on reset stretch
  localparam int AUX_POR_CYC   = (AUX_POR_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int PCI_CLK_MAX_MHZ = 66;   // highest bus clock accepted

  // ---------------------------------------------------------------
  // link ordered-set figures, counted in symbol times
  // ---------------------------------------------------------------
  localparam int TS1_RESET_COUNT = 1024;
  localparam int SKP_MIN_SYM     = 1180;
  localparam int SKP_MAX_SYM     = 1538;
  localparam int HOT_TS_COUNT    = 2;
  localparam int TS_CNT_W        = 11;

  // ---------------------------------------------------------------
  // ordered-set type codes on the rx and tx strobes
  // ---------------------------------------------------------------
  localparam logic [1:0] OS_TS1  = 2'h0;
  localparam logic [1:0] OS_TS2  = 2'h1;
  localparam logic [1:0] OS_SKP  = 2'h2;
  localparam logic [1:0] OS_EIOS = 2'h3;

  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {TX_OFF, TX_TS1, TX_EIOS, TX_EIDLE} tx_state_e;
  typedef enum logic {PCI_IDLE, PCI_ACTIVE} pci_state_e;

endpackage

// ### sync2.sv
// two flip-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  // data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // sync2

// ### bridge_reset_hotplug_control.sv
// reset propagation, link reset training and hot-plug control of the bridge
`timescale 1ns/1ps
module bridge_reset_hotplug_control
  import bridge_reset_pkg::*;
#(
  parameter int HP_EVENTS = 4,
  parameter int SKP_SCHED = SKP_MIN_SYM
) (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  // straps and supplies
  input  wire logic                 reverse_mode_select,
  input  wire logic                 add_in_card,
  input  wire logic                 aux_core_supply,
  // link fundamental reset pin
  input  wire logic                 link_fundamental_reset_n_in,
  output logic                      link_fundamental_reset_n_out,
  output logic                      link_fundamental_reset_n_oe,
  // pci bus reset pin
  input  wire logic                 pci_reset_n_in,
  output logic                      pci_reset_n_out,
  output logic                      pci_reset_n_oe,
  // internal reset outputs
  output logic                      core_reset_n,
  output logic                      soft_reset_n,
  output logic                      pcie_func_reset_n,
  output logic                      aux_reset_n,
  // link receive side
  input  wire logic                 link_clk,
  input  wire logic                 link_down_state,
  input  wire logic                 rx_os_valid,
  input  wire logic [1:0]           rx_os_type,
  input  wire logic                 rx_os_reset,
  output logic                      rx_skip_seen,
  output logic                      hot_reset,
  // link transmit side
  output logic                      tx_os_valid,
  output logic [1:0]                tx_os_type,
  output logic                      tx_os_reset,
  output logic                      tx_elec_idle,
  // hot plug
  input  wire logic [HP_EVENTS-1:0] card_event,
  output logic                      hp_pci_side,
  output logic                      hp_pcie_side,
  output logic                      hp_msg_valid,
  output logic [$clog2(HP_EVENTS)-1:0] hp_msg_index,
  // pci bus interface
  input  wire logic                 pci_frame_n,
  input  wire logic                 pci_trdy_n,
  input  wire logic                 addr_hit,
  input  wire logic                 irq_req,
  output logic                      pci_busy,
  output logic                      pci_out_oe,
  output logic                      pci_resp_take,
  output logic                      pci_interrupt_a_n_out,
  output logic                      pci_interrupt_a_n_oe
);

  localparam int SW = 8 + HP_EVENTS;
  localparam int HW = $clog2(HP_EVENTS);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [SW-1:0]        pin_s;
  logic                 rev_s;
  logic                 add_in_s;
  logic                 aux_s;
  logic                 perst_s;
  logic                 pci_rst_s;
  logic                 lclk_s;
  logic                 frame_s;
  logic                 trdy_s;
  logic [HP_EVENTS-1:0] card_s;

  sync2 #(.WIDTH(SW)) u_sync (
    .mclk (mclk),
    .nrst (nrst),
    .d    ({card_event, add_in_card, pci_trdy_n, pci_frame_n, link_clk, pci_reset_n_in,
            link_fundamental_reset_n_in, aux_core_supply, reverse_mode_select}),
    .q    (pin_s)
  );

  // split synchronised pins; add-in strap sits just below the card bits
  assign rev_s     = pin_s[0];
  assign aux_s     = pin_s[1];
  assign perst_s   = pin_s[2];
  assign pci_rst_s = pin_s[3];
  assign lclk_s    = pin_s[4];
  assign frame_s   = pin_s[5];
  assign trdy_s    = pin_s[6];
  assign add_in_s  = pin_s[7];
  assign card_s    = pin_s[SW-1:8];

  // ---------------------------------------------------------------
  // reset selection and propagation
  // ---------------------------------------------------------------
  logic fwd;
  logic sel_rst;
  logic pcie_side_reset;
  logic pci_bus_rst;
  logic next_pci_rst_drive;

  // internal reset source picked by bridge direction
  assign fwd             = !rev_s;
  assign sel_rst         = rev_s ? pci_rst_s : perst_s;
  // any link-side reset in forward mode
  assign pcie_side_reset = !perst_s || hot_reset || link_down_state;
  assign next_pci_rst_drive = fwd && pcie_side_reset;
  assign pci_bus_rst     = fwd ? !pci_reset_n_out : !pci_rst_s;

  // reset pins: each is driven only in the mode that owns it
  assign pci_reset_n_oe              = fwd;
  assign link_fundamental_reset_n_oe = rev_s;

  // functions follow whichever side owns the link reset
  assign pcie_func_reset_n = fwd ? perst_s : link_fundamental_reset_n_out;

  // registered reset outputs
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      core_reset_n                 <= 1'b0;
      soft_reset_n                 <= 1'b0;
      pci_reset_n_out              <= 1'b0;
      link_fundamental_reset_n_out <= 1'b0;
    end else begin
      core_reset_n    <= sel_rst;
      soft_reset_n    <= sel_rst && !link_down_state && !hot_reset;
      pci_reset_n_out <= !next_pci_rst_drive;
      link_fundamental_reset_n_out <= !(rev_s && !pci_rst_s);
    end
  end

  // ---------------------------------------------------------------
  // aux power-on reset
  // ---------------------------------------------------------------
  logic [5:0] por_cnt;
  logic       por_done;

  assign por_done = (por_cnt == 6'(AUX_POR_CYC));

  // stretch aux reset after the aux core supply is seen
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      por_cnt     <= '0;
      aux_reset_n <= 1'b0;
    end else if (!aux_s) begin
      por_cnt     <= '0;
      aux_reset_n <= 1'b0;
    end else begin
      por_cnt     <= por_done ? por_cnt : por_cnt + 6'h01;
      aux_reset_n <= por_done;
    end
  end

  // ---------------------------------------------------------------
  // receive side: hot reset detect and skp acceptance
  // ---------------------------------------------------------------
  logic       rx_is_ts;
  logic       rx_ts_rst;
  logic [1:0] hot_cnt;
  logic       next_hot;

  assign rx_is_ts  = rx_os_valid && (rx_os_type == OS_TS1 || rx_os_type == OS_TS2);
  assign rx_ts_rst = rx_is_ts && rx_os_reset;
  assign next_hot  = rx_ts_rst && (hot_cnt == 2'(HOT_TS_COUNT - 1));

  // count consecutive reset-bit training sets; skp does not break a run
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hot_cnt      <= '0;
      hot_reset    <= 1'b0;
      rx_skip_seen <= 1'b0;
    end else begin
      rx_skip_seen <= rx_os_valid && rx_os_type == OS_SKP;
      if (rev_s || link_down_state) begin
        hot_cnt   <= '0;
        hot_reset <= 1'b0;
      end else if (rx_ts_rst) begin
        hot_cnt   <= next_hot ? hot_cnt : hot_cnt + 2'h1;
        hot_reset <= hot_reset || next_hot;
      end else if (rx_is_ts || (rx_os_valid && rx_os_type == OS_EIOS)) begin
        hot_cnt   <= '0;
        hot_reset <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // transmit side: reset training burst in reverse mode
  // ---------------------------------------------------------------
  tx_state_e             tx_state;
  tx_state_e             next_tx_state;
  logic                  lclk_d;
  logic                  sym_tick;
  logic [TS_CNT_W-1:0]   ts_cnt;
  logic [TS_CNT_W-1:0]   skp_cnt;
  logic                  skp_due;
  logic                  ts_last;

  // one symbol slot per rising edge of the sampled link clock
  assign sym_tick = lclk_s && !lclk_d;
  assign skp_due  = (skp_cnt >= TS_CNT_W'(SKP_SCHED));
  assign ts_last  = (ts_cnt == TS_CNT_W'(TS1_RESET_COUNT - 1));

  // burst sequencing
  always_comb begin
    next_tx_state = tx_state;
    unique case (tx_state)
      TX_OFF: begin
        if (rev_s && !pci_rst_s) next_tx_state = TX_TS1;
      end
      TX_TS1: begin
        if (sym_tick && !skp_due && ts_last) next_tx_state = TX_EIOS;
      end
      TX_EIOS: begin
        if (sym_tick) next_tx_state = TX_EIDLE;
      end
      TX_EIDLE: begin
        if (pci_rst_s || !rev_s) next_tx_state = TX_OFF;
      end
    endcase
  end

  assign tx_elec_idle = (tx_state == TX_EIDLE);

  // ordered-set strobes and counters
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_state    <= TX_OFF;
      lclk_d      <= 1'b0;
      ts_cnt      <= '0;
      skp_cnt     <= '0;
      tx_os_valid <= 1'b0;
      tx_os_type  <= OS_TS1;
      tx_os_reset <= 1'b0;
    end else begin
      lclk_d      <= lclk_s;
      tx_state    <= next_tx_state;
      tx_os_valid <= 1'b0;
      if (tx_state == TX_TS1 && sym_tick) begin
        tx_os_valid <= 1'b1;
        if (skp_due) begin
          tx_os_type  <= OS_SKP;
          tx_os_reset <= 1'b0;
          skp_cnt     <= '0;
        end else begin
          tx_os_type  <= OS_TS1;
          tx_os_reset <= 1'b1;
          ts_cnt      <= ts_cnt + TS_CNT_W'(1);
          skp_cnt     <= skp_cnt + TS_CNT_W'(1);
        end
      end else if (tx_state == TX_EIOS && sym_tick) begin
        tx_os_valid <= 1'b1;
        tx_os_type  <= OS_EIOS;
        tx_os_reset <= 1'b0;
      end else if (tx_state == TX_OFF) begin
        ts_cnt  <= '0;
        skp_cnt <= '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // hot plug side select and card messages
  // ---------------------------------------------------------------
  logic [HP_EVENTS-1:0] card_d;
  logic [HP_EVENTS-1:0] card_chg;

  // lowest changed card condition wins
  function automatic logic [HW-1:0] first_set(input logic [HP_EVENTS-1:0] v);
    first_set = '0;
    for (int i = HP_EVENTS - 1; i >= 0; i--) begin
      if (v[i]) first_set = HW'(i);
    end
  endfunction

  assign hp_pci_side  = !rev_s;
  assign hp_pcie_side = rev_s;
  assign card_chg     = card_s ^ card_d;

  // one message per cycle of card condition change, for the lowest changed one, on an add-in card in forward mode
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      card_d       <= '0;
      hp_msg_valid <= 1'b0;
      hp_msg_index <= '0;
    end else begin
      card_d       <= card_s;
      hp_msg_valid <= fwd && add_in_s && |card_chg;
      hp_msg_index <= first_set(card_chg);
    end
  end

  // ---------------------------------------------------------------
  // pci bus interface idle control, bus clocks up to 66 MHz
  // ---------------------------------------------------------------
  pci_state_e pci_state;
  pci_state_e next_pci_state;
  logic       claim;

  // only an address phase that decodes here leaves idle
  assign claim = !pci_bus_rst && !frame_s && addr_hit;

  always_comb begin
    next_pci_state = pci_state;
    unique case (pci_state)
      PCI_IDLE: begin
        if (claim && !link_down_state) next_pci_state = PCI_ACTIVE;
      end
      PCI_ACTIVE: begin
        if (frame_s && trdy_s) next_pci_state = PCI_IDLE;
      end
    endcase
    // reset and link loss force idle, dropping the transaction
    if (pci_bus_rst || link_down_state) next_pci_state = PCI_IDLE;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pci_state <= PCI_IDLE;
    end else begin
      pci_state <= next_pci_state;
    end
  end

  // bus drivers released during reset, responses ignored while idle
  assign pci_busy              = (pci_state == PCI_ACTIVE);
  assign pci_out_oe            = pci_busy && !pci_bus_rst;
  assign pci_resp_take         = pci_busy && !trdy_s;
  assign pci_interrupt_a_n_out = 1'b0;
  assign pci_interrupt_a_n_oe  = irq_req && !pci_bus_rst;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_fwd_core_src: assert property (fwd && !perst_s |=> !core_reset_n)
    else $error("core reset not following link reset in forward mode");
  a_rev_core_src: assert property (rev_s && !pci_rst_s |=> !core_reset_n)
    else $error("core reset not following pci reset in reverse mode");
  a_hp_side_sel: assert property (hp_pcie_side == rev_s && hp_pci_side != hp_pcie_side)
    else $error("hot-plug side does not match mode");
  a_hp_msg_gate: assert property (hp_msg_valid |-> $past(fwd) && $past(add_in_s))
    else $error("hot-plug message outside forward add-in use");
  a_pci_tristate: assert property (pci_bus_rst |-> !pci_out_oe && !pci_interrupt_a_n_oe)
    else $error("pci driven during bus reset");
  a_pci_idle_rst: assert property (pci_bus_rst |=> !pci_busy)
    else $error("pci interface left idle in reset");
  a_pci_claim: assert property ($rose(pci_busy) |-> $past(addr_hit) && !$past(frame_s))
    else $error("pci left idle without address claim");
  a_resp_ignore: assert property (!pci_busy |-> !pci_resp_take)
    else $error("target response taken while idle");
  a_hot_entry: assert property (fwd && !link_down_state && next_hot |=> hot_reset)
    else $error("hot reset not entered after two reset sets");
  a_link_down: assert property (link_down_state |=> !soft_reset_n && !pci_busy)
    else $error("link down did not reset logic");
  a_fwd_pci_rst: assert property (fwd && pcie_side_reset |=> !pci_reset_n_out)
    else $error("pci reset not asserted on link reset");
  a_pci_rst_rel: assert property ($rose(pci_reset_n_out) && $past(fwd) |-> !$past(pcie_side_reset))
    else $error("pci reset released before link reset");
  a_ts1_burst: assert property ($rose(tx_state == TX_EIOS) |-> ts_cnt == TS1_RESET_COUNT)
    else $error("reset burst length is not 1024");
  a_skp_bound: assert property (skp_cnt <= SKP_MAX_SYM)
    else $error("skp interval exceeded");
  a_eios_idle: assert property (tx_os_valid && tx_os_type == OS_EIOS |-> tx_elec_idle)
    else $error("no electrical idle after eios");
  a_func_rst: assert property (fwd && !perst_s |-> !pcie_func_reset_n)
    else $error("functions not held in link reset");
  a_perst_hold: assert property (rev_s && !pci_rst_s ##1 rev_s && !pci_rst_s
                                 |-> !link_fundamental_reset_n_out)
    else $error("link reset released while pci reset held");
  a_aux_por: assert property ($rose(aux_reset_n) |-> por_done && $past(aux_s))
    else $error("aux reset released early");

endmodule // bridge_reset_hotplug_control

// ### far_side_model.sv
// far-side model: link clock source and tally of received ordered sets
`timescale 1ns/1ps
module far_side_model
  import bridge_reset_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // link clock control and transmit side of the bridge
  input  wire logic       run,
  output logic            link_clk,
  input  wire logic       tx_os_valid,
  input  wire logic [1:0] tx_os_type,
  input  wire logic       tx_os_reset,
  // tallies
  output int              n_ts1,
  output int              n_eios,
  output int              n_skp
);
  // link clock: 400 ns, odd phase, stands still while run is low
  initial begin
    link_clk = 1'b0;
    #137;
    forever begin
      #200;
      link_clk = run ? ~link_clk : 1'b0;
    end
  end

  // count each kind of ordered set the bridge sends
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      n_ts1 <= 0;
      n_eios <= 0;
      n_skp <= 0;
    end else if (tx_os_valid) begin
      if (tx_os_type == OS_TS1 && tx_os_reset) n_ts1 <= n_ts1 + 1;
      if (tx_os_type == OS_EIOS) n_eios <= n_eios + 1;
      if (tx_os_type == OS_SKP) n_skp <= n_skp + 1;
    end
  end
endmodule // far_side_model

// ### bridge_reset_hotplug_control_test.sv
// self-checking bench of the bridge reset and hot-plug control block
`timescale 1ns/1ps
module bridge_reset_hotplug_control_test;
  import bridge_reset_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic mclk, nrst, reverse_mode_select, add_in_card, aux_core_supply;
  logic perst_drv, host_rst, run, link_clk, link_down_state;
  logic link_n_out, link_n_oe, pci_n_out, pci_n_oe, core_reset_n, soft_reset_n;
  logic pcie_func_reset_n, aux_reset_n, rx_os_valid, rx_os_reset, rx_skip_seen;
  logic hot_reset, tx_os_valid, tx_os_reset, tx_elec_idle, hp_pci_side;
  logic hp_pcie_side, hp_msg_valid, pci_frame_n, pci_trdy_n, addr_hit, irq_req;
  logic pci_busy, pci_out_oe, pci_resp_take, irq_n_out, irq_n_oe;
  logic [1:0] rx_os_type, tx_os_type, hp_msg_index;
  logic [3:0] card_event;
  int n_ts1, n_eios, n_skp, n_mismatch, checks_done, cyc;
  // reset wires resolved from every driver
  wire link_n_wire = link_n_oe ? link_n_out : perst_drv;
  wire pci_n_wire = pci_n_oe ? pci_n_out : host_rst;

  bridge_reset_hotplug_control i_bridge_reset_hotplug_control (
    .mclk, .nrst, .reverse_mode_select, .add_in_card, .aux_core_supply,
    .link_fundamental_reset_n_in(link_n_wire), .link_fundamental_reset_n_out(link_n_out),
    .link_fundamental_reset_n_oe(link_n_oe), .pci_reset_n_in(pci_n_wire),
    .pci_reset_n_out(pci_n_out), .pci_reset_n_oe(pci_n_oe), .core_reset_n,
    .soft_reset_n, .pcie_func_reset_n, .aux_reset_n, .link_clk, .link_down_state,
    .rx_os_valid, .rx_os_type, .rx_os_reset, .rx_skip_seen, .hot_reset, .tx_os_valid,
    .tx_os_type, .tx_os_reset, .tx_elec_idle, .card_event, .hp_pci_side, .hp_pcie_side,
    .hp_msg_valid, .hp_msg_index, .pci_frame_n, .pci_trdy_n, .addr_hit, .irq_req,
    .pci_busy, .pci_out_oe, .pci_resp_take, .pci_interrupt_a_n_out(irq_n_out),
    .pci_interrupt_a_n_oe(irq_n_oe));

  far_side_model i_far_side_model (.mclk, .nrst, .run, .link_clk, .tx_os_valid,
    .tx_os_type, .tx_os_reset, .n_ts1, .n_eios, .n_skp);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // cycle ceiling against hangs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 14000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  // one received ordered set, strobed for one cycle
  task automatic send_os(input logic [1:0] t, input logic r);
    @(negedge mclk);
    rx_os_valid = 1'b1;
    rx_os_type = t;
    rx_os_reset = r;
    @(negedge mclk);
    rx_os_valid = 1'b0;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_aux();
    aux_core_supply = 1'b1;
    w(10);
    chk(aux_reset_n, 1'b0, "aux reset early");
    w(20);
    chk(aux_reset_n, 1'b1, "aux reset stuck");
    $display("test aux done");
  endtask

  task automatic t_forward();
    run = 1'b1;
    w(5);
    chk(core_reset_n, 1'b0, "core out of reset");
    chk(pci_n_out, 1'b0, "pci reset not driven");
    chk(pcie_func_reset_n, 1'b0, "functions not held");
    chk({hp_pci_side, hp_pcie_side}, 2'h2, "hot-plug side");
    perst_drv = 1'b1; // clock already running before release
    w(1);
    chk(pci_n_out, 1'b0, "pci reset left early");
    w(5);
    chk({core_reset_n, pcie_func_reset_n}, 2'h3, "core still reset");
    chk(pci_n_out, 1'b1, "pci reset kept");
    $display("test forward done");
  endtask

  task automatic t_pci();
    pci_trdy_n = 1'b0;
    w(4);
    chk({pci_busy, pci_resp_take}, 2'h0, "idle response taken");
    pci_frame_n = 1'b0;
    w(4);
    chk(pci_busy, 1'b0, "unclaimed phase");
    addr_hit = 1'b1;
    w(1);
    addr_hit = 1'b0;
    w(2);
    chk({pci_busy, pci_out_oe, pci_resp_take}, 3'h7, "claimed phase");
    irq_req = 1'b1;
    w(1);
    chk({irq_n_oe, irq_n_out}, 2'h2, "interrupt not driven");
    perst_drv = 1'b0;
    w(5);
    chk({pci_busy, pci_out_oe, irq_n_oe}, 3'h0, "bus not released");
    chk({pci_n_out, pcie_func_reset_n}, 2'h0, "reset not passed");
    addr_hit = 1'b1;
    w(4);
    chk(pci_busy, 1'b0, "left idle in reset");
    addr_hit = 1'b0;
    {pci_frame_n, pci_trdy_n, irq_req} = 3'h6;
    perst_drv = 1'b1;
    w(6);
    chk({pci_busy, pci_n_out}, 2'h1, "busy after reset");
    $display("test pci done");
  endtask

  task automatic t_hot();
    send_os(OS_TS1, 1'b1);
    send_os(OS_TS1, 1'b0);
    w(2);
    chk(hot_reset, 1'b0, "hot reset on one set");
    send_os(OS_TS1, 1'b1);
    send_os(OS_TS2, 1'b1);
    w(2);
    chk(hot_reset, 1'b1, "no hot reset");
    w(2);
    chk({pci_n_out, soft_reset_n}, 2'h0, "hot reset not passed");
    send_os(OS_TS1, 1'b0);
    w(4);
    chk({hot_reset, pci_n_out}, 2'h1, "hot reset stuck");
    link_down_state = 1'b1;
    w(4);
    chk({soft_reset_n, pci_n_out}, 2'h0, "link down ignored");
    link_down_state = 1'b0;
    w(4);
    chk({soft_reset_n, pci_n_out}, 2'h3, "link down stuck");
    @(negedge mclk);
    {rx_os_valid, rx_os_type} = {1'b1, OS_SKP};
    @(negedge mclk);
    rx_os_valid = 1'b0;
    chk(rx_skip_seen, 1'b1, "skip not seen");
    w(1);
    chk(rx_skip_seen, 1'b0, "skip pulse long");
    $display("test hot done");
  endtask

  task automatic t_hotplug();
    int k;
    add_in_card = 1'b1;
    card_event = 4'h4;
    k = 0;
    while (hp_msg_valid !== 1'b1 && k < 8) begin
      w(1);
      k++;
    end
    chk(hp_msg_valid, 1'b1, "no hot-plug message");
    chk(hp_msg_index, 2'h2, "hot-plug index");
    $display("test hotplug done");
  endtask

  task automatic t_reverse();
    int k;
    {reverse_mode_select, host_rst, run} = 3'h5;
    w(5);
    chk({link_n_oe, link_n_out}, 2'h2, "link reset not driven");
    chk({core_reset_n, pcie_func_reset_n}, 2'h0, "reverse core reset");
    chk({hp_pci_side, hp_pcie_side}, 2'h1, "reverse hot-plug side");
    k = 0;
    while (tx_elec_idle !== 1'b1 && k < 10000) begin
      w(1);
      k++;
    end
    chk(tx_elec_idle, 1'b1, "no electrical idle");
    w(1); // eios tally lands one edge after the strobe
    chk(n_ts1[15:0], TS1_RESET_COUNT[15:0], "reset sets count");
    chk({n_eios[7:0], n_skp[7:0]}, 16'h0100, "eios or skip count");
    chk(link_n_out, 1'b0, "link reset dropped");
    run = 1'b0;
    host_rst = 1'b1;
    w(6);
    chk({link_n_out, core_reset_n, tx_elec_idle}, 3'h6, "reverse release");
    $display("test reverse done");
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {nrst, reverse_mode_select, add_in_card, aux_core_supply, perst_drv} = 5'h0;
    {host_rst, run, link_down_state, rx_os_valid, rx_os_reset, irq_req} = 6'h20;
    {rx_os_type, card_event, pci_frame_n, pci_trdy_n, addr_hit} = 9'h6;
    {n_mismatch, checks_done, cyc} = 0;
    w(4);
    nrst = 1'b1;
    w(3);
    t_aux();
    t_forward();
    t_pci();
    t_hot();
    t_hotplug();
    t_reverse();
    final_report();
  end
endmodule // bridge_reset_hotplug_control_test
